// ---- hw/osw_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module osw_ctrl
    import osw_pkg::*;
#(
    parameter int TH_PERIOD = OSW_TH_PERIOD,
    parameter int TH_ON = OSW_TH_ON
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe,
    input wire logic [OSW_PAR_CHANNELS-1:0] parallel_drive_input,
    input wire logic input_polarity_select,
    input wire osw_fault_type [OSW_CHANNELS-1:0] chan_fault,
    output logic [OSW_CHANNELS-1:0] power_channel_line,
    output logic fault_o,
    output logic fault_oe
);
    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // Link and pins sampled through two flops
    osw_link_type link_s;
    logic [OSW_PAR_CHANNELS-1:0] par_s;
    logic pol_s;
    logic res_s;
    osw_fault_type [OSW_CHANNELS-1:0] fault_s;

    // Reset to the idle pin levels, so no false select edge follows reset
    osw_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_link_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({sclk, cs_n, si}),
        .q(link_s)
    );
    osw_sync #(.WIDTH(OSW_PAR_CHANNELS + 2)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({parallel_drive_input, input_polarity_select, reset_n}),
        .q({par_s, pol_s, res_s})
    );
    // Fault levels come from the analog side and are not clock aligned
    osw_sync #(.WIDTH($bits(osw_fault_type) * OSW_CHANNELS)) u_fault_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(chan_fault),
        .q(fault_s)
    );

    logic sclk_d_r;
    logic cs_d_r;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [OSW_CNT_W-1:0] cnt_r;
    logic [7:0] latch_r;
    logic so_r;
    logic so_oe_r;
    logic diag_clear_r;

    wire cs_fall = cs_d_r && !link_s.cs_n;
    wire cs_rise = !cs_d_r && link_s.cs_n;
    wire sclk_fall = sclk_d_r && !link_s.sclk;
    wire sclk_rise = !sclk_d_r && link_s.sclk;
    wire active = !link_s.cs_n && !cs_fall;
    wire frame_ok = cnt_r == OSW_CNT_W'(OSW_FRAME_BITS);
    wire [7:0] ctrl_byte = shift_r[15:8];
    wire [7:0] data_byte = shift_r[7:0];
    wire apply = cs_rise && frame_ok && ctrl_byte != OSW_CTRL_DIAG_ONLY;

    logic [OSW_CHANNELS-1:0] chan_drive;
    logic [OSW_CHANNELS-1:0] chan_err;
    logic [2*OSW_CHANNELS-1:0] diag_word;
    logic [OSW_CHANNELS-1:0] cmd_on;

    // Floating parallel inputs are assumed pulled to their inactive level
    wire [OSW_PAR_CHANNELS-1:0] par_act = pol_s ? par_s : ~par_s;

    genvar gi;
    generate
        for (gi = 0; gi < OSW_CHANNELS; gi++) begin : g_chan
            if (gi < OSW_PAR_CHANNELS) begin : g_par
                assign cmd_on[gi] = latch_r[gi] && par_act[gi];
            end else begin : g_ser
                assign cmd_on[gi] = latch_r[gi];
            end
            osw_diag_chan #(.TH_PERIOD(TH_PERIOD), .TH_ON(TH_ON)) u_diag (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .cmd_on(cmd_on[gi]),
                .fault(fault_s[gi]),
                .clear(diag_clear_r),
                .drive(chan_drive[gi]),
                .code(diag_word[2*gi+1 -: 2]),
                .err(chan_err[gi])
            );
        end
    endgenerate

    always_comb begin
        shift_nxt = shift_r;
        if (cs_fall)
            shift_nxt = diag_word;
        else if (active && sclk_fall)
            shift_nxt = {shift_r[14:0], link_s.si};
        else if (active && sclk_rise)
            shift_nxt = shift_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else if (ce) begin
            sclk_d_r <= link_s.sclk;
            cs_d_r <= link_s.cs_n;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= OSW_SHIFT_RESET;
            cnt_r <= '0;
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
        end else if (ce) begin
            if (!res_s) begin
                shift_r <= OSW_SHIFT_RESET;
                cnt_r <= '0;
            end else begin
                shift_r <= shift_nxt;
                if (cs_fall)
                    cnt_r <= '0;
                else if (active && sclk_fall && cnt_r != '1)
                    cnt_r <= cnt_r + 1'b1;
            end
            if (cs_fall) begin
                so_r <= diag_word[15];
                so_oe_r <= 1'b1;
            end else if (link_s.cs_n) begin
                so_oe_r <= 1'b0;
            end else if (active && sclk_rise) begin
                // Shifter only moves on falls, so bit 14 is the next one out
                so_r <= shift_r[14];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= OSW_LATCH_RESET;
            diag_clear_r <= 1'b0;
        end else if (ce) begin
            diag_clear_r <= cs_rise;
            if (!res_s)
                latch_r <= OSW_LATCH_RESET;
            else if (apply)
                latch_r <= data_byte;
        end
    end

    assign power_channel_line = res_s ? chan_drive : '0;
    assign so_o = so_r;
    assign so_oe = so_oe_r;
    assign fault_o = 1'b0;
    assign fault_oe = |chan_err;
endmodule : osw_ctrl
`default_nettype wire

// ---- pkg/osw_pkg.sv ----
`default_nettype none
package osw_pkg;
    localparam int OSW_CHANNELS = 8;
    localparam int OSW_PAR_CHANNELS = 4;
    localparam int OSW_FRAME_BITS = 16;
    localparam int OSW_CNT_W = 5;
    localparam logic [7:0] OSW_CTRL_DIAG_ONLY = 8'h00;
    localparam logic [7:0] OSW_LATCH_RESET = 8'h00;
    localparam logic [15:0] OSW_SHIFT_RESET = 16'h0000;
    // Diagnostic codes per channel
    localparam logic [1:0] OSW_DIAG_NORMAL = 2'b11;
    localparam logic [1:0] OSW_DIAG_OVERLOAD = 2'b10;
    localparam logic [1:0] OSW_DIAG_OPEN = 2'b01;
    localparam logic [1:0] OSW_DIAG_SHORT_GND = 2'b00;
    // Thermal restart pattern: on cycles out of period
    localparam int OSW_TH_PERIOD = 4000;
    localparam int OSW_TH_ON = 400;

    typedef struct packed {
        logic overload;
        logic overtemp;
        logic open_load;
        logic short_gnd;
    } osw_fault_type;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic si;
    } osw_link_type;
endpackage : osw_pkg
`default_nettype wire

// ---- hw/osw_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module osw_sync
    import osw_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("osw_sync: width must be at least one");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
    assign q = q_r;
endmodule : osw_sync
`default_nettype wire

// ---- hw/osw_diag_chan.sv ----
`timescale 1ns/10ps
`default_nettype none
module osw_diag_chan
    import osw_pkg::*;
#(
    parameter int TH_PERIOD = OSW_TH_PERIOD,
    parameter int TH_ON = OSW_TH_ON
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmd_on,
    input wire osw_fault_type fault,
    input wire logic clear,
    output logic drive,
    output logic [1:0] code,
    output logic err
);
    if (TH_ON < 1 || TH_ON >= TH_PERIOD) begin : g_bad_duty
        $error("osw_diag_chan: bad thermal duty");
    end

    localparam int TW = $clog2(TH_PERIOD);
    logic [TW-1:0] th_cnt_r;
    logic [1:0] code_r;
    logic err_r;

    wire [1:0] now_code = fault.overload || fault.overtemp ? OSW_DIAG_OVERLOAD :
                          fault.short_gnd ? OSW_DIAG_SHORT_GND :
                          fault.open_load ? OSW_DIAG_OPEN : OSW_DIAG_NORMAL;
    wire now_err = now_code != OSW_DIAG_NORMAL;
    wire th_on = th_cnt_r < TW'(TH_ON);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            th_cnt_r <= '0;
            code_r <= OSW_DIAG_NORMAL;
            err_r <= 1'b0;
        end else if (ce) begin
            if (!fault.overtemp || th_cnt_r == TW'(TH_PERIOD - 1))
                th_cnt_r <= '0;
            else
                th_cnt_r <= th_cnt_r + 1'b1;
            // A new error wins over the clear and overwrites the old one
            if (now_err) begin
                code_r <= now_code;
                err_r <= 1'b1;
            end else if (clear) begin
                code_r <= OSW_DIAG_NORMAL;
                err_r <= 1'b0;
            end
        end
    end

    assign drive = cmd_on && (!fault.overtemp || th_on);
    assign code = code_r;
    assign err = err_r;
endmodule : osw_diag_chan
`default_nettype wire

// ---- verification/osw_ctrl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module osw_ctrl_asserts
    import osw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic [3:0] parallel_drive_input,
    input wire logic input_polarity_select,
    input wire osw_fault_type [7:0] chan_fault,
    input wire logic [7:0] power_channel_line,
    input wire logic fault_o,
    input wire logic fault_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic [3:0] par_on = parallel_drive_input ^ {4{~input_polarity_select}};
    a_so_idle: assert property (cs_n [*6] |-> !so_oe)
        else $error("so driven while idle");
    a_so_enable: assert property ($fell(cs_n) |-> ##[3:5] so_oe)
        else $error("so not enabled");
    a_so_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("so not released");
    a_so_steady: assert property ((!cs_n && !sclk) [*6] |=> $stable(so_o))
        else $error("so moved without clock");
    a_fault_flag: assert property (reset_n && $rose(|chan_fault) |-> ##[1:6] fault_oe)
        else $error("fault flag late");
    a_fault_held: assert property (fault_oe && !cs_n |=> fault_oe && !fault_o)
        else $error("fault flag dropped while selected");
    a_reset_off: assert property ((!reset_n) [*5] |-> power_channel_line == 8'h00)
        else $error("channels on in reset");
    a_par_gate: assert property ($stable(par_on) [*5] |->
        (power_channel_line[3:0] & ~par_on) == 4'h0) else $error("parallel gate open");
    a_latch_hold: assert property ((cs_n && reset_n) [*8]
        |=> $stable(power_channel_line[7:4])) else $error("latch moved while idle");
    c_frame: cover property ($rose(so_oe));
    c_fault: cover property ($rose(fault_oe));
    c_apply: cover property (cs_n && $changed(power_channel_line));
endmodule : osw_ctrl_asserts
bind osw_ctrl osw_ctrl_asserts u_chk (.*);
`default_nettype wire

// ---- verification/osw_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module osw_host (
    input wire logic clk,
    input wire logic so,
    output logic sclk,
    output logic cs_n,
    output logic si,
    output logic [15:0] rx
);
    // Idle levels match the pin pulls: clock and data low, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx = 16'h0000;
    end
    task automatic xfer(input logic [15:0] w, input int n, input logic sel);
        cs_n <= ~sel;
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (i < 16) rx[15 - i] <= so;
            sclk <= 1'b1;
            si <= (i < 16) ? w[15 - i] : 1'b0;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        si <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : osw_host
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import osw_pkg::*;
    localparam int TH_P = 20;
    localparam int TH_N = 4;
    logic clk = 1'b0, arst_n = 1'b0, reset_n = 1'b1, pol = 1'b1;
    logic [3:0] pdi = 4'h0;
    osw_fault_type [7:0] flt = '0;
    logic [7:0] lat = 8'h00, ctl = 8'h00, dat = 8'h00;
    logic [15:0] pend = 16'hffff;
    logic [31:0] r;
    int nlist[4] = '{16, 16, 15, 17};
    int seed = 32479, cyc = 0, mismatches = 0, n_compared = 0, on_cnt = 0;
    wire logic sclk, cs_n, si, so_o, so_oe, so_w, fault_o, fault_oe;
    wire logic [7:0] pcl;
    wire logic [15:0] rx;
    // A released line shows the inverse, so a stale bit cannot pass for data
    assign so_w = so_oe ? so_o : ~so_o;
    osw_ctrl #(.TH_PERIOD(TH_P), .TH_ON(TH_N)) dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
        .parallel_drive_input(pdi), .input_polarity_select(pol), .chan_fault(flt),
        .power_channel_line(pcl), .fault_o(fault_o), .fault_oe(fault_oe));
    osw_host host (.clk(clk), .so(so_w), .sclk(sclk), .cs_n(cs_n), .si(si), .rx(rx));
    initial forever #25 clk = ~clk;
    function automatic logic [7:0] exp_ch();
        return lat & {4'hf, pdi ^ {4{~pol}}};
    endfunction : exp_ch
    function automatic logic [15:0] exp_diag();
        logic [15:0] d;
        for (int c = 0; c < 8; c++) begin
            d[2*c+:2] = (flt[c].overload || flt[c].overtemp) ? OSW_DIAG_OVERLOAD :
                flt[c].short_gnd ? OSW_DIAG_SHORT_GND :
                flt[c].open_load ? OSW_DIAG_OPEN : OSW_DIAG_NORMAL;
        end
        return d;
    endfunction : exp_diag
    task automatic cmp_ch(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : cmp_ch
    task automatic cmp_so(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : cmp_so
    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // Latched errors outlive the fault until the next select rise
    task automatic frame(input int n);
        logic [15:0] ed;
        ed = (flt != '0) ? exp_diag() : pend;
        host.xfer({ctl, dat}, n, 1'b1);
        if (n == 16 && ctl != OSW_CTRL_DIAG_ONLY) lat = dat;
        pend = exp_diag();
        cmp_so("diag", ed, rx);
        cmp_ch("channels", exp_ch(), pcl);
    endtask : frame
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_ch("channels", 8'h00, pcl);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            ctl = (i % 4 == 1) ? 8'h00 : r[7:0];
            dat = r[15:8];
            pdi <= r[19:16];
            pol <= r[20];
            @(posedge clk);
            frame(nlist[i % 4]);
        end
        flt <= 32'h8002_0010;
        repeat (10) @(posedge clk);
        cmp_ch("fault_flag", 8'h01, {7'h00, fault_oe});
        ctl = 8'hff;
        dat = 8'hff;
        frame(16);
        flt <= '0;
        @(posedge clk);
        frame(16);
        frame(16);
        cmp_ch("fault_flag", 8'h00, {7'h00, fault_oe});
        // Overtemperature on channel 0 gates its drive to the restart duty
        pdi <= 4'hf;
        pol <= 1'b1;
        flt <= 32'h0000_0004;
        repeat (4) @(posedge clk);
        pend = exp_diag();
        repeat (2 * TH_P) begin
            @(posedge clk);
            on_cnt += pcl[0];
        end
        cmp_ch("thermal_duty", 8'(2 * TH_N), on_cnt[7:0]);
        flt <= '0;
        @(posedge clk);
        frame(16);
        host.xfer(16'h0000, 16, 1'b0);
        cmp_ch("channels", exp_ch(), pcl);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_ch("channels", 8'h00, pcl);
        reset_n <= 1'b1;
        lat = 8'h00;
        ctl = 8'h00;
        repeat (4) @(posedge clk);
        frame(16);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
